// *** pst_pkg.sv ***
// package: constants, types and register map for the strap sampler
package pst_pkg;
    // behaviour encodings (one-hot)
    typedef enum logic [3:0] {
        PST_NORMAL = 4'h1,
        PST_MOD_CONT = 4'h2,
        PST_SINGLE_PKT = 4'h4,
        PST_UNMOD_CARRIER = 4'h8
    } pst_mode_t;
    // channel codes
    localparam logic [2:0] PST_CH_A = 3'h0;
    localparam logic [2:0] PST_CH_B = 3'h1;
    localparam logic [2:0] PST_CH_C = 3'h2;
    localparam logic [2:0] PST_CH_D = 3'h3;
    localparam logic [2:0] PST_CH_STORED = 3'h4;
    // sampler states
    typedef enum logic [2:0] {
        PST_S_WAIT = 3'h1,
        PST_S_SETTLE = 3'h2,
        PST_S_HELD = 3'h4
    } pst_state_t;
    // settle time before sampling, ns, and its cycle count at 125 MHz
    localparam int PST_SETTLE_NS = 1000;
    localparam int PST_CLK_MHZ = 125;
    localparam int PST_SETTLE_CYC = (PST_SETTLE_NS * PST_CLK_MHZ + 999) / 1000;
    // test pattern: 72 bits, msb first
    localparam int PST_PAT_W = 72;
    localparam logic [71:0] PST_PATTERN = 72'h80AAF0F0F0AAF0F0F0;
    // register byte offsets
    localparam logic [7:0] PST_OFF_STATUS = 8'h00;
    localparam logic [7:0] PST_OFF_DEFCH = 8'h04;
    localparam logic [7:0] PST_OFF_CTRL = 8'h08;
    localparam logic [7:0] PST_OFF_PAT0 = 8'h0C;
    localparam logic [7:0] PST_OFF_PAT1 = 8'h10;
    localparam logic [7:0] PST_OFF_PAT2 = 8'h14;
    // field positions
    localparam int PST_ST_MODE_LSB = 0;
    localparam int PST_ST_CH_LSB = 4;
    localparam int PST_ST_DONE_BIT = 8;
    localparam int PST_ST_RAW_LSB = 12;
    localparam int PST_CTRL_TXEN_BIT = 0;
    // reset values
    localparam logic [1:0] PST_DEFCH_RST = 2'h0;
    localparam logic PST_TXEN_RST = 1'b0;
    // decoded selection carried as one bundle
    typedef struct packed {
        pst_mode_t mode;
        logic [2:0] chan;
    } pst_sel_t;
endpackage

// *** pst_sync.sv ***
// two-flop synchroniser for a group of pins
`timescale 1ns/1ps
module pst_sync #(
    parameter int W = 4
) (
    // clocking
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // unconnected pins pull high, so reset to ones
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= {W{1'b1}};
            q <= {W{1'b1}};
        end else if (ce) begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// *** pst_strap.sv ***
// power-up strap sampler, test-behaviour decoder and test bit serialiser
`timescale 1ns/1ps
module pst_strap (
    // clock and reset
    input wire logic CLOCK,
    input wire logic ARST_N,
    input wire logic CE,
    // strap pins, pulled high externally
    input wire logic TEST_SELECT_A,
    input wire logic TEST_SELECT_B,
    input wire logic SERIAL_RX,
    input wire logic SERIAL_RTS,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // transmitter controls
    output logic [3:0] MODE,
    output logic [2:0] CHANNEL,
    output logic SAMPLED,
    output logic TX_ON,
    output logic CARRIER_ONLY,
    output logic TX_BIT,
    output logic TX_BIT_VALID
);
    logic [3:0] pins_s;
    logic [3:0] raw_q;
    pst_pkg::pst_state_t state_q;
    logic [15:0] settle_q;
    pst_pkg::pst_sel_t sel_q;
    pst_pkg::pst_sel_t sel_d;
    logic [1:0] defch_q;
    logic txen_q;
    logic [6:0] bit_q;
    logic pkt_done_q;
    logic acc;

    // strap pins pass two flops before any logic reads them
    pst_sync #(.W(4)) u_sync (
        .clk(CLOCK),
        .arst_n(ARST_N),
        .ce(CE),
        .d({TEST_SELECT_A, TEST_SELECT_B, SERIAL_RX, SERIAL_RTS}),
        .q(pins_s)
    );

    // access phase of an apb transfer
    assign acc = PSEL && PENABLE;

    // decode of straps into behaviour and channel
    always_comb begin
        sel_d.chan = pst_pkg::PST_CH_STORED;
        case (pins_s[3:2])
            2'b00: sel_d.mode = pst_pkg::PST_MOD_CONT;
            2'b01: sel_d.mode = pst_pkg::PST_SINGLE_PKT;
            2'b10: sel_d.mode = pst_pkg::PST_UNMOD_CARRIER;
            default: sel_d.mode = pst_pkg::PST_NORMAL;
        endcase
        if (pins_s[3:2] != 2'b11) begin
            case (pins_s[1:0])
                2'b00: sel_d.chan = pst_pkg::PST_CH_B;
                2'b01: sel_d.chan = pst_pkg::PST_CH_C;
                2'b10: sel_d.chan = pst_pkg::PST_CH_D;
                default: sel_d.chan = pst_pkg::PST_CH_STORED;
            endcase
        end
    end

    // one-time sampler: settle then latch, held until next reset
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= pst_pkg::PST_S_WAIT;
            settle_q <= 16'h0000;
            sel_q <= '{mode: pst_pkg::PST_NORMAL, chan: pst_pkg::PST_CH_STORED};
            raw_q <= 4'hF;
        end else if (CE) begin
            case (state_q)
                pst_pkg::PST_S_WAIT: begin
                    state_q <= pst_pkg::PST_S_SETTLE;
                end
                pst_pkg::PST_S_SETTLE: begin
                    if (settle_q == 16'(pst_pkg::PST_SETTLE_CYC - 1)) begin
                        sel_q <= sel_d;
                        raw_q <= pins_s;
                        state_q <= pst_pkg::PST_S_HELD;
                    end else begin
                        settle_q <= settle_q + 16'h0001;
                    end
                end
                pst_pkg::PST_S_HELD: begin
                    state_q <= pst_pkg::PST_S_HELD;
                end
                default: state_q <= pst_pkg::PST_S_WAIT;
            endcase
        end
    end

    // software registers: stored default channel and transmit enable
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            defch_q <= pst_pkg::PST_DEFCH_RST;
            txen_q <= pst_pkg::PST_TXEN_RST;
        end else if (CE && acc && PWRITE) begin
            if (PADDR == pst_pkg::PST_OFF_DEFCH) begin
                defch_q <= PWDATA[1:0];
            end else if (PADDR == pst_pkg::PST_OFF_CTRL) begin
                txen_q <= PWDATA[pst_pkg::PST_CTRL_TXEN_BIT];
            end
        end
    end

    // apb read data, zero-wait answer
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
            PREADY <= 1'b0;
        end else if (CE) begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
            if (PSEL && !PENABLE) begin
                if (PADDR == pst_pkg::PST_OFF_STATUS) begin
                    PRDATA[pst_pkg::PST_ST_MODE_LSB +: 4] <= sel_q.mode;
                    PRDATA[pst_pkg::PST_ST_CH_LSB +: 3] <= sel_q.chan;
                    PRDATA[pst_pkg::PST_ST_DONE_BIT] <=
                        (state_q == pst_pkg::PST_S_HELD);
                    PRDATA[pst_pkg::PST_ST_RAW_LSB +: 4] <= raw_q;
                end else if (PADDR == pst_pkg::PST_OFF_DEFCH) begin
                    PRDATA[1:0] <= defch_q;
                end else if (PADDR == pst_pkg::PST_OFF_CTRL) begin
                    PRDATA[0] <= txen_q;
                end else if (PADDR == pst_pkg::PST_OFF_PAT0) begin
                    PRDATA <= pst_pkg::PST_PATTERN[31:0];
                end else if (PADDR == pst_pkg::PST_OFF_PAT1) begin
                    PRDATA <= pst_pkg::PST_PATTERN[63:32];
                end else if (PADDR == pst_pkg::PST_OFF_PAT2) begin
                    PRDATA[7:0] <= pst_pkg::PST_PATTERN[71:64];
                end else begin
                    PSLVERR <= 1'b1;
                end
            end
        end
    end

    // pattern serialiser: loops in continuous mode, stops after one pass
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            bit_q <= 7'h00;
            pkt_done_q <= 1'b0;
            TX_BIT <= 1'b0;
            TX_BIT_VALID <= 1'b0;
        end else if (CE) begin
            TX_BIT_VALID <= 1'b0;
            if (state_q == pst_pkg::PST_S_HELD && txen_q && !pkt_done_q &&
                (sel_q.mode == pst_pkg::PST_MOD_CONT ||
                 sel_q.mode == pst_pkg::PST_SINGLE_PKT)) begin
                TX_BIT <= pst_pkg::PST_PATTERN[7'(pst_pkg::PST_PAT_W - 1)
                    - bit_q];
                TX_BIT_VALID <= 1'b1;
                if (bit_q == 7'(pst_pkg::PST_PAT_W - 1)) begin
                    bit_q <= 7'h00;
                    pkt_done_q <= (sel_q.mode == pst_pkg::PST_SINGLE_PKT);
                end else begin
                    bit_q <= bit_q + 7'h01;
                end
            end
        end
    end

    // control outputs from flops, channel resolves stored default
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            MODE <= pst_pkg::PST_NORMAL;
            CHANNEL <= pst_pkg::PST_CH_A;
            SAMPLED <= 1'b0;
            TX_ON <= 1'b0;
            CARRIER_ONLY <= 1'b0;
        end else if (CE) begin
            MODE <= sel_q.mode;
            CHANNEL <= (sel_q.chan == pst_pkg::PST_CH_STORED) ?
                {1'b0, defch_q} : sel_q.chan;
            SAMPLED <= (state_q == pst_pkg::PST_S_HELD);
            CARRIER_ONLY <= (state_q == pst_pkg::PST_S_HELD) &&
                (sel_q.mode == pst_pkg::PST_UNMOD_CARRIER);
            TX_ON <= (state_q == pst_pkg::PST_S_HELD) && txen_q &&
                sel_q.mode != pst_pkg::PST_NORMAL && !pkt_done_q;
        end
    end

    // sampled selection never changes once held
    held_stable_a: assert property (@(posedge CLOCK)
        disable iff (!ARST_N)
        state_q == pst_pkg::PST_S_HELD |=> $stable(sel_q))
        else $error("selection changed after sampling");
    // both selects high gives normal mode and stored channel
    normal_decode_a: assert property (@(posedge CLOCK)
        disable iff (!ARST_N)
        CE && state_q == pst_pkg::PST_S_SETTLE && pins_s[3:2] == 2'b11 &&
        settle_q == 16'(pst_pkg::PST_SETTLE_CYC - 1) |=>
        sel_q.mode == pst_pkg::PST_NORMAL &&
        sel_q.chan == pst_pkg::PST_CH_STORED)
        else $error("normal strap decoded wrongly");
    // channel strap 01 maps to C in test modes
    chan_map_a: assert property (@(posedge CLOCK)
        disable iff (!ARST_N)
        pins_s[3:2] != 2'b11 && pins_s[1:0] == 2'b01 |->
        sel_d.chan == pst_pkg::PST_CH_C)
        else $error("channel strap map wrong");
    // stored default used when both channel straps high
    stored_ch_a: assert property (@(posedge CLOCK)
        disable iff (!ARST_N)
        CE && SAMPLED && sel_q.chan == pst_pkg::PST_CH_STORED |=>
        CHANNEL == {1'b0, $past(defch_q)})
        else $error("stored channel not applied");
    // serialiser emits pattern msb first
    first_bit_a: assert property (@(posedge CLOCK)
        disable iff (!ARST_N)
        CE && TX_BIT_VALID == 1'b0 && bit_q == 7'h00 &&
        state_q == pst_pkg::PST_S_HELD && txen_q && !pkt_done_q &&
        sel_q.mode == pst_pkg::PST_MOD_CONT |=> TX_BIT == 1'b1)
        else $error("first pattern bit wrong");
    // single packet mode falls silent after its one pass
    single_stop_a: assert property (@(posedge CLOCK)
        disable iff (!ARST_N)
        CE && pkt_done_q |=> !TX_BIT_VALID &&
        sel_q.mode == pst_pkg::PST_SINGLE_PKT)
        else $error("packet stopped in wrong mode");
    // carrier only in unmodulated test
    carrier_only_a: assert property (@(posedge CLOCK)
        disable iff (!ARST_N)
        CARRIER_ONLY |-> MODE == pst_pkg::PST_UNMOD_CARRIER && !TX_BIT_VALID)
        else $error("carrier output in wrong mode");
    // sampling completes within 300 cycles of entering settle
    sample_time_a: assert property (@(posedge CLOCK)
        disable iff (!ARST_N)
        CE && $rose(state_q == pst_pkg::PST_S_SETTLE) |->
        ##[1:300] (state_q == pst_pkg::PST_S_HELD || !CE))
        else $error("sampling did not complete");

    cont_c: cover property (@(posedge CLOCK) disable iff (!ARST_N)
        TX_BIT_VALID && sel_q.mode == pst_pkg::PST_MOD_CONT &&
        bit_q == 7'h00);
    single_c: cover property (@(posedge CLOCK) disable iff (!ARST_N)
        $rose(pkt_done_q));
    carrier_c: cover property (@(posedge CLOCK) disable iff (!ARST_N)
        $rose(CARRIER_ONLY));
endmodule

// *** pst_fixture.sv ***
// test fixture model: grounds chosen strap pins, others float high
`timescale 1ns/1ps
module pst_fixture (
    // pins to ground, order {select a, select b, rx, rts}
    input wire logic [3:0] gnd,
    // resulting pin levels
    output logic [3:0] pins
);
    // grounded pin reads 0, open pin is pulled up to 1
    assign pins = ~gnd;
endmodule

// *** powerup_strap_test_mode_select_test.sv ***
// self-checking bench for the strap sampler
`timescale 1ns/1ps
module powerup_strap_test_mode_select_test;
    logic CLOCK = 1'b0;
    logic ARST_N = 1'b0;
    logic CE = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, SAMPLED, TX_ON, CARRIER_ONLY, TX_BIT, TX_BIT_VALID;
    logic [3:0] MODE;
    logic [2:0] CHANNEL;
    logic [3:0] gnd = 4'h0;
    logic [3:0] pins;
    logic [31:0] rd;
    logic err;
    logic [143:0] bits;
    int n_fail = 0;
    int check_count = 0;

    // 125 MHz clock
    always #4 CLOCK = ~CLOCK;

    pst_fixture i_fix (.gnd(gnd), .pins(pins));

    pst_strap i_dut (
        .CLOCK(CLOCK), .ARST_N(ARST_N), .CE(CE),
        .TEST_SELECT_A(pins[3]), .TEST_SELECT_B(pins[2]),
        .SERIAL_RX(pins[1]), .SERIAL_RTS(pins[0]),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .MODE(MODE), .CHANNEL(CHANNEL), .SAMPLED(SAMPLED), .TX_ON(TX_ON),
        .CARRIER_ONLY(CARRIER_ONLY), .TX_BIT(TX_BIT),
        .TX_BIT_VALID(TX_BIT_VALID)
    );

    // verdict and end of run
    task automatic complete_run();
        if (n_fail == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic give_up();
        n_fail++;
        complete_run();
    endtask

    // one apb transfer, waits for pready with a bound
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
            if (n > 20) give_up();
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    // straps set before power, then power-up and wait for the latch
    task automatic power_up(input logic [3:0] g);
        int n;
        @(posedge CLOCK);
        ARST_N <= 1'b0;
        gnd <= g;
        repeat (3) @(posedge CLOCK);
        ARST_N <= 1'b1;
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
            if (n > 400) give_up();
        end while (SAMPLED !== 1'b1);
    endtask

    function automatic logic [3:0] exp_mode(input logic [3:0] p);
        case (p[3:2])
            2'b00: return pst_pkg::PST_MOD_CONT;
            2'b01: return pst_pkg::PST_SINGLE_PKT;
            2'b10: return pst_pkg::PST_UNMOD_CARRIER;
            default: return pst_pkg::PST_NORMAL;
        endcase
    endfunction

    // stored default is the reset value of the default channel, A
    function automatic logic [2:0] exp_chan(input logic [3:0] p);
        if (p[3:2] == 2'b11) return pst_pkg::PST_CH_A;
        case (p[1:0])
            2'b00: return pst_pkg::PST_CH_B;
            2'b01: return pst_pkg::PST_CH_C;
            2'b10: return pst_pkg::PST_CH_D;
            default: return pst_pkg::PST_CH_A;
        endcase
    endfunction

    // every strap combination, then pins changed after the latch
    task automatic strap_table();
        for (int i = 0; i < 16; i++) begin
            power_up(~i[3:0]);
            chk(MODE, exp_mode(i[3:0]));
            chk(CHANNEL, exp_chan(i[3:0]));
            chk(CARRIER_ONLY, i[3:2] == 2'b10);
            apb(1'b0, pst_pkg::PST_OFF_STATUS, 32'h0);
            chk(rd[15:12], i[3:0]);
            chk({rd[8], rd[3:0]}, {1'b1, exp_mode(i[3:0])});
            gnd <= i[3:0];
            repeat (20) @(posedge CLOCK);
            chk({MODE, CHANNEL}, {exp_mode(i[3:0]), exp_chan(i[3:0])});
        end
    endtask

    // collect count valid bits, msb of the stream first
    task automatic grab(input int count);
        int n;
        n = 0;
        for (int k = 0; k < count; k++) begin
            do begin
                @(posedge CLOCK);
                n++;
                if (n > 2000) give_up();
            end while (TX_BIT_VALID !== 1'b1);
            bits = {bits[142:0], TX_BIT};
        end
    endtask

    // continuous and single pattern transmission
    task automatic serialiser();
        int n;
        power_up(4'hC);
        apb(1'b1, pst_pkg::PST_OFF_CTRL, 32'h1);
        grab(144);
        chk(bits[143:72] == pst_pkg::PST_PATTERN, 1'b1);
        chk(bits[71:0] == pst_pkg::PST_PATTERN, 1'b1);
        chk(TX_ON, 1'b1);
        power_up(4'h8);
        apb(1'b1, pst_pkg::PST_OFF_CTRL, 32'h1);
        grab(72);
        chk(bits[71:0] == pst_pkg::PST_PATTERN, 1'b1);
        n = 0;
        repeat (300) begin
            @(posedge CLOCK);
            n += TX_BIT_VALID;
        end
        chk(n, 0);
        chk(TX_ON, 1'b0);
    endtask

    // register access: pattern words, default channel, unmapped address
    task automatic registers();
        apb(1'b0, pst_pkg::PST_OFF_PAT0, 32'h0);
        chk(rd, pst_pkg::PST_PATTERN[31:0]);
        apb(1'b0, pst_pkg::PST_OFF_PAT1, 32'h0);
        chk(rd, pst_pkg::PST_PATTERN[63:32]);
        apb(1'b0, pst_pkg::PST_OFF_PAT2, 32'h0);
        chk(rd[7:0], pst_pkg::PST_PATTERN[71:64]);
        apb(1'b0, pst_pkg::PST_OFF_DEFCH, 32'h0);
        chk(rd[1:0], pst_pkg::PST_DEFCH_RST);
        apb(1'b1, pst_pkg::PST_OFF_DEFCH, 32'h3);
        apb(1'b0, pst_pkg::PST_OFF_DEFCH, 32'h0);
        chk(rd[1:0], 2'h3);
        chk(CHANNEL, pst_pkg::PST_CH_D);
        apb(1'b0, 8'h40, 32'h0);
        chk(err, 1'b1);
    endtask

    // clock enable low holds off sampling, then the carrier test
    task automatic ce_hold();
        int n;
        @(posedge CLOCK);
        ARST_N <= 1'b0;
        CE <= 1'b0;
        gnd <= 4'h4;
        repeat (3) @(posedge CLOCK);
        ARST_N <= 1'b1;
        repeat (200) @(posedge CLOCK);
        chk(SAMPLED, 1'b0);
        CE <= 1'b1;
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
            if (n > 400) give_up();
        end while (SAMPLED !== 1'b1);
        chk(MODE, pst_pkg::PST_UNMOD_CARRIER);
        chk(CARRIER_ONLY, 1'b1);
        apb(1'b1, pst_pkg::PST_OFF_CTRL, 32'h1);
        repeat (10) @(posedge CLOCK);
        chk(TX_ON, 1'b1);
        chk(TX_BIT_VALID, 1'b0);
    endtask

    initial begin
        repeat (3) @(posedge CLOCK);
        ARST_N <= 1'b1;
        strap_table();
        serialiser();
        registers();
        ce_hold();
        complete_run();
    end
endmodule
